// ### bench/dbo_chk.sv
// Concurrent checks on the APB side and fetch outputs of the offset bank
`timescale 1ns/1ps
module dbo_chk
  import dbo_pkg::*;
#(
  parameter int BASE_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              cursor_start,
  input wire logic              cursor_advance,
  input wire logic [BASE_W-1:0] cur_fetch_addr,
  input wire logic [PIX_W-1:0]  pixel_offset
);
  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic ofs_rd;
  logic wr_fb;
  assign mapped = paddr inside {FB_START_ADDR, CB_START_ADDR, CUR_START_ADDR,
                                LINE_DELTA_ADDR, STATUS_ADDR};
  assign ofs_rd = !pwrite && paddr inside {FB_START_ADDR, CB_START_ADDR, CUR_START_ADDR};
  assign wr_fb  = psel && penable && pwrite && paddr == FB_START_ADDR;
  sequence s_step;
    cursor_advance && !cursor_start ##1 !cursor_advance && !cursor_start;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_after: assert property ($rose(psel && penable) |=> pready)
    else $error("pready late");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_rsvd_zero: assert property (pready && ofs_rd |-> prdata[31:22] == 10'h000)
    else $error("reserved offset bits not zero");
  // Low 22 bits only, so any base and the aperture wrap both hold
  a_cursor_step: assert property (s_step |=>
    ((cur_fetch_addr - $past(cur_fetch_addr)) & 32'h003F_FFFF) == 32'h4)
    else $error("cursor step not one dword");
  a_pix_cause: assert property ($changed(pixel_offset) |->
    $past(wr_fb, 1) || $past(wr_fb, 2) || $past(wr_fb, 3))
    else $error("pixel offset moved without write");
endmodule
bind display_buffer_offset_regs dbo_chk #(.BASE_W(BASE_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .cursor_start, .cursor_advance, .cur_fetch_addr, .pixel_offset
);

// ### bench/tb.sv
// Self-checking bench for the display buffer offset register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import dbo_pkg::*;
  localparam logic [31:0] BASE = 32'h0100_0000;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] aperture_base = BASE;
  logic [31:0] prdata, fb_a, cb_a, cur_a, q;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  pixel_offset;
  logic        pready, pslverr, err;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #20 pclk = ~pclk;
  display_buffer_offset_regs #(.BASE_W(32)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .aperture_base_field(aperture_base), .frame_start(ev[0]),
    .line_advance(ev[1]), .cursor_start(ev[2]), .cursor_advance(ev[3]),
    .fb_fetch_addr(fb_a), .cb_fetch_addr(cb_a), .cur_fetch_addr(cur_a), .pixel_offset
  );
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // No local limit: only the bench timeout ends a hung transfer
    do begin @(posedge pclk); end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic kick(input logic [3:0] e);
    ev <= e;
    @(posedge pclk);
    ev <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    // Compression is never enabled here, so nonzero frame offsets are legal
    apb(1, FB_START_ADDR, 32'h0001_2347);
    apb(0, FB_START_ADDR, 0); `CHK("frame", 32'h0001_2347, q)
    `CHK("pixel", 4'h7, pixel_offset)
    apb(0, STATUS_ADDR, 0); `CHK("pending", 32'h0040_0007, q)
    apb(1, CB_START_ADDR, 32'h0003_0000);
    apb(1, CUR_START_ADDR, 32'h003F_FFFC);
    apb(1, LINE_DELTA_ADDR, 32'h0020_0010);
    kick(4'h1);
    apb(0, STATUS_ADDR, 0); `CHK("active", 32'h0001_2347, q)
    `CHK("fb addr", BASE + 32'h0001_2340, fb_a)
    `CHK("cb addr", BASE + 32'h0003_0000, cb_a)
    kick(4'h2);
    `CHK("fb line", BASE + 32'h0001_2380, fb_a)
    `CHK("cb line", BASE + 32'h0003_0080, cb_a)
    // Only the low byte lane is enabled: the other lanes must keep their value
    pstrb <= 4'h1;
    apb(1, LINE_DELTA_ADDR, 32'hFFFF_FF08);
    pstrb <= 4'hF;
    apb(0, LINE_DELTA_ADDR, 0); `CHK("delta", 32'h0020_0008, q)
    kick(4'h2);
    `CHK("fb line 2", BASE + 32'h0001_23A0, fb_a)
    `CHK("cb line 2", BASE + 32'h0003_0100, cb_a)
    // Pan mid-frame: pixel moves now, the coarse part waits for the frame start
    apb(1, FB_START_ADDR, 32'h0000_5678);
    apb(0, STATUS_ADDR, 0); `CHK("pan pending", 32'h0041_2348, q)
    `CHK("pan pixel", 4'h8, pixel_offset)
    `CHK("pan held", BASE + 32'h0001_23A0, fb_a)
    kick(4'h1);
    `CHK("pan fb addr", BASE + 32'h0000_5670, fb_a)
    `CHK("pan cb addr", BASE + 32'h0003_0000, cb_a)
    kick(4'h4); `CHK("cursor", BASE + 32'h003F_FFFC, cur_a)
    kick(4'h8); `CHK("cursor wrap", BASE, cur_a)
    kick(4'h8); `CHK("cursor step", BASE + 32'h4, cur_a)
    apb(0, CB_START_ADDR, 0); `CHK("cb", 32'h0003_0000, q)
    apb(0, CUR_START_ADDR, 0); `CHK("cur", 32'h003F_FFFC, q)
    apb(0, 16'h8330, 0); `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    // Moving the aperture moves every fetch address with it
    aperture_base <= 32'h0200_0000;
    kick(4'h0);
    `CHK("new base cur", 32'h0200_0004, cur_a)
    `CHK("new base fb", 32'h0200_5670, fb_a)
    give_verdict();
  end
endmodule

// ### core/dbo_addr_gen.sv
// Fetch address generator: line walk for frame and compressed, linear cursor
`timescale 1ns/1ps
module dbo_addr_gen
  import dbo_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  dbo_offset_if.gen              ofs,
  input  wire logic              frame_start,
  input  wire logic              line_advance,
  input  wire logic              cursor_start,
  input  wire logic              cursor_advance,
  output logic      [OFS_W-1:0]  fb_line_ofs,
  output logic      [OFS_W-1:0]  cb_line_ofs,
  output logic      [OFS_W-1:0]  cur_ofs
);
  logic [OFS_W-1:0] fb_r, fb_nxt, cb_r, cb_nxt, cur_r, cur_nxt;
  // Wraps modulo 4 MB so no address leaves the aperture
  always_comb begin
    fb_nxt  = fb_r;
    cb_nxt  = cb_r;
    cur_nxt = cur_r;
    if (frame_start) begin
      fb_nxt = ofs.frame_ofs;
      cb_nxt = ofs.comp_ofs;
    end else if (line_advance) begin
      // Delta counts doublewords
      fb_nxt = fb_r + OFS_W'({ofs.fb_delta, 2'b00});
      cb_nxt = cb_r + OFS_W'({ofs.cb_delta, 2'b00});
    end
    if (cursor_start) begin
      cur_nxt = ofs.cursor_ofs;
    end else if (cursor_advance) begin
      cur_nxt = cur_r + OFS_W'(4);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_r  <= OFS_RESET;
      cb_r  <= OFS_RESET;
      cur_r <= OFS_RESET;
    end else begin
      fb_r  <= fb_nxt;
      cb_r  <= cb_nxt;
      cur_r <= cur_nxt;
    end
  end
  assign fb_line_ofs = fb_r;
  assign cb_line_ofs = cb_r;
  assign cur_ofs     = cur_r;
endmodule

// ### core/dbo_offset_if.sv
// Carries the active offsets from the register file to the address generator
`timescale 1ns/1ps
interface dbo_offset_if;
  import dbo_pkg::*;
  logic [OFS_W-1:0]   frame_ofs;
  logic [OFS_W-1:0]   comp_ofs;
  logic [OFS_W-1:0]   cursor_ofs;
  logic [DELTA_W-1:0] fb_delta;
  logic [DELTA_W-1:0] cb_delta;
  modport regs (output frame_ofs, comp_ofs, cursor_ofs, fb_delta, cb_delta);
  modport gen  (input  frame_ofs, comp_ofs, cursor_ofs, fb_delta, cb_delta);
endinterface

// ### core/dbo_pkg.sv
// Constants and types for the display buffer offset register bank
// Overview of operation
// - All buffers confined to 4 MB aperture
// - Base from memory controller, offsets added
// - Three independent programmable buffer start offsets
// - Next line start adds line delta
// - Cursor fetched linearly, no line delta
// - Five 32-bit registers at 8310h-832Ch
// - Frame start is 22-bit byte offset
// - Frame bits 21:4 apply at frame start
// - Frame pixel offset bits 3:0 immediate
package dbo_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          OFS_W           = 22;
  localparam int          APERTURE_BYTES  = 4194304;
  localparam int          DELTA_W         = 10;
  localparam int          PIX_W           = 4;
  localparam logic [15:0] FB_START_ADDR   = 16'h8310;
  localparam logic [15:0] CB_START_ADDR   = 16'h8314;
  localparam logic [15:0] CUR_START_ADDR  = 16'h8318;
  localparam logic [15:0] LINE_DELTA_ADDR = 16'h8324;
  localparam logic [15:0] STATUS_ADDR     = 16'h832C;
  localparam logic [21:0] OFS_RESET       = 22'h000000;
  localparam logic [9:0]  DELTA_RESET     = 10'h000;
  typedef enum logic [1:0] {FETCH_IDLE, FETCH_LINE, FETCH_CURSOR} fetch_state_t;
endpackage

// ### core/display_buffer_offset_regs.sv
// APB register bank holding buffer start offsets and forming fetch addresses
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module display_buffer_offset_regs
  import dbo_pkg::*;
#(
  parameter int BASE_W = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [BASE_W-1:0] aperture_base_field,
  input  wire logic              frame_start,
  input  wire logic              line_advance,
  input  wire logic              cursor_start,
  input  wire logic              cursor_advance,
  output logic      [BASE_W-1:0] fb_fetch_addr,
  output logic      [BASE_W-1:0] cb_fetch_addr,
  output logic      [BASE_W-1:0] cur_fetch_addr,
  output logic      [PIX_W-1:0]  pixel_offset
);
  // Base narrower than the offset would drop aperture bits
  if (BASE_W < OFS_W || BASE_W > 32) begin : g_base_check
    $error("BASE_W must lie between OFS_W and 32");
  end

  logic [OFS_W-1:0]   fb_prog_r, fb_prog_nxt;
  logic [OFS_W-1:0]   fb_act_r, fb_act_nxt;
  logic [OFS_W-1:0]   cb_r, cb_nxt, cur_r, cur_nxt;
  logic [DELTA_W-1:0] fbd_r, fbd_nxt, cbd_r, cbd_nxt;
  logic               pend_r, pend_nxt;
  logic [31:0]        prdata_nxt;
  logic               pready_nxt, pslverr_nxt;
  logic               acc, wr, hit;
  logic [31:0]        wmask;

  for (genvar gi = 0; gi < 4; gi++) begin : g_wmask
    assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
  end

  // Two-cycle access phase: decode on the first penable cycle, pready on the next
  assign acc = psel && penable && !pready;
  assign wr  = acc && pwrite;

  always_comb begin
    fb_prog_nxt = fb_prog_r;
    fb_act_nxt  = fb_act_r;
    cb_nxt      = cb_r;
    cur_nxt     = cur_r;
    fbd_nxt     = fbd_r;
    cbd_nxt     = cbd_r;
    pend_nxt    = pend_r;
    prdata_nxt  = 32'h00000000;
    pready_nxt  = acc;
    pslverr_nxt = 1'b0;
    hit         = 1'b1;
    // Reserved bits 31:22 of the three offset registers are dropped and read back as zero
    if (paddr == FB_START_ADDR) begin
      prdata_nxt = {10'h000, fb_prog_r};
      if (wr) begin
        fb_prog_nxt = OFS_W'((pwdata & wmask) | ({10'h000, fb_prog_r} & ~wmask));
        pend_nxt    = 1'b1;
      end
    end else if (paddr == CB_START_ADDR) begin
      prdata_nxt = {10'h000, cb_r};
      if (wr) begin
        cb_nxt = OFS_W'((pwdata & wmask) | ({10'h000, cb_r} & ~wmask));
      end
    end else if (paddr == CUR_START_ADDR) begin
      prdata_nxt = {10'h000, cur_r};
      if (wr) begin
        cur_nxt = OFS_W'((pwdata & wmask) | ({10'h000, cur_r} & ~wmask));
      end
    end else if (paddr == LINE_DELTA_ADDR) begin
      prdata_nxt = {6'h00, cbd_r, 6'h00, fbd_r};
      if (wr) begin
        if (pstrb[0]) fbd_nxt[7:0] = pwdata[7:0];
        if (pstrb[1]) fbd_nxt[9:8] = pwdata[9:8];
        if (pstrb[2]) cbd_nxt[7:0] = pwdata[23:16];
        if (pstrb[3]) cbd_nxt[9:8] = pwdata[25:24];
      end
    end else if (paddr == STATUS_ADDR) begin
      prdata_nxt = {9'h000, pend_r, fb_act_r};
    end else begin
      hit = 1'b0;
    end
    if (acc && !hit) begin
      pslverr_nxt = 1'b1;
    end
    if (!acc) begin
      prdata_nxt = 32'h00000000;
    end
    // Pixel offset follows the programmed value at once
    fb_act_nxt[PIX_W-1:0] = fb_prog_nxt[PIX_W-1:0];
    // Coarse address waits for frame start so the current frame stays intact
    if (frame_start) begin
      fb_act_nxt[OFS_W-1:PIX_W] = fb_prog_r[OFS_W-1:PIX_W];
      pend_nxt = wr && (paddr == FB_START_ADDR);
      if (pend_nxt) begin
        fb_act_nxt[OFS_W-1:PIX_W] = fb_prog_nxt[OFS_W-1:PIX_W];
        pend_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_prog_r <= OFS_RESET;
      fb_act_r  <= OFS_RESET;
      cb_r      <= OFS_RESET;
      cur_r     <= OFS_RESET;
      fbd_r     <= DELTA_RESET;
      cbd_r     <= DELTA_RESET;
      pend_r    <= 1'b0;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      fb_prog_r <= fb_prog_nxt;
      fb_act_r  <= fb_act_nxt;
      cb_r      <= cb_nxt;
      cur_r     <= cur_nxt;
      fbd_r     <= fbd_nxt;
      cbd_r     <= cbd_nxt;
      pend_r    <= pend_nxt;
      prdata    <= prdata_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
    end
  end

  dbo_offset_if ofs_bus ();
  assign ofs_bus.frame_ofs  = {fb_act_nxt[OFS_W-1:PIX_W], {PIX_W{1'b0}}};
  assign ofs_bus.comp_ofs   = cb_r;
  assign ofs_bus.cursor_ofs = cur_r;
  assign ofs_bus.fb_delta   = fbd_r;
  assign ofs_bus.cb_delta   = cbd_r;

  logic [OFS_W-1:0] fb_line, cb_line, cur_line;
  dbo_addr_gen u_gen (
    .pclk           (pclk),
    .presetn        (presetn),
    .ofs            (ofs_bus),
    .frame_start    (frame_start),
    .line_advance   (line_advance),
    .cursor_start   (cursor_start),
    .cursor_advance (cursor_advance),
    .fb_line_ofs    (fb_line),
    .cb_line_ofs    (cb_line),
    .cur_ofs        (cur_line)
  );

  logic [BASE_W-1:0] fb_addr_nxt, cb_addr_nxt, cur_addr_nxt;
  // Only the 22 offset bits ever reach the adder
  always_comb begin
    fb_addr_nxt  = aperture_base_field + BASE_W'(fb_line);
    cb_addr_nxt  = aperture_base_field + BASE_W'(cb_line);
    cur_addr_nxt = aperture_base_field + BASE_W'(cur_line);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_fetch_addr  <= '0;
      cb_fetch_addr  <= '0;
      cur_fetch_addr <= '0;
      pixel_offset   <= '0;
    end else begin
      fb_fetch_addr  <= fb_addr_nxt;
      cb_fetch_addr  <= cb_addr_nxt;
      cur_fetch_addr <= cur_addr_nxt;
      pixel_offset   <= fb_act_r[PIX_W-1:0];
    end
  end
endmodule
